/* File: hdl/duty_select.sv */
// Per-output duty source selection, minimum clamp and low-duty cutoff
`timescale 1ns/10ps
module duty_select (
    input wire logic use_loop,
    input wire fan_bind_pkg::duty_t loop_duty,
    input wire fan_bind_pkg::duty_t table_duty,
    input wire fan_bind_pkg::duty_t min_duty,
    input wire logic cutoff_en,
    input wire fan_bind_pkg::duty_t cutoff_level,
    output fan_bind_pkg::duty_t duty_out,
    output logic shut_off
);
    fan_bind_pkg::duty_t clamped;
    fan_bind_pkg::duty_t request;

    assign clamped = (loop_duty < min_duty) ? min_duty : loop_duty;
    assign request = use_loop ? clamped : table_duty;

    assign shut_off = cutoff_en && (request < cutoff_level);
    assign duty_out = shut_off ? fan_bind_pkg::DUTY_ZERO : request;
endmodule

/* File: hdl/fan_bind_regs.sv */
// Fan control binding, cutoff and loop limit registers with routing logic
`timescale 1ns/10ps
module fan_bind_regs (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire fan_bind_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    input wire logic [2:0] out2_filter_coeff,
    input wire fan_bind_pkg::zone_temps_t zone_temps,
    input wire fan_bind_pkg::temp_t loop_target,
    input wire fan_bind_pkg::duty_t loop_duty,
    input wire fan_bind_pkg::duty_t table1_duty,
    input wire fan_bind_pkg::duty_t table2_duty,
    output fan_bind_pkg::table_temps_t table_temps,
    output fan_bind_pkg::duty_t out1_duty,
    output fan_bind_pkg::duty_t out2_duty,
    output logic out2_cut_active,
    output logic loop_uses_zone1,
    output logic loop_uses_zone2,
    output fan_bind_pkg::temp_t loop_hot_temp,
    output logic loop_above_target,
    output logic loop_below_band,
    output logic [3:0] loop_hysteresis,
    output fan_bind_pkg::duty_t loop_min_duty
);
    logic [7:0] shutoff_reg;
    logic [7:0] bindings_reg;
    logic [7:0] min_hyst_reg;
    logic [4:0] out2_low_duty_cutoff;
    fan_bind_pkg::duty_t cutoff_level;
    fan_bind_pkg::duty_t min_duty;
    fan_bind_pkg::duty_t out1_next;
    fan_bind_pkg::duty_t out2_next;
    logic out2_cut_next;
    logic cutoff_en;
    fan_bind_pkg::temp_t hot_next;
    logic [8:0] hot_half;
    logic [8:0] target_half;
    logic [9:0] band_floor_half;
    logic [7:0] rdata_next;

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    function automatic fan_bind_pkg::temp_t pick(input logic sel,
        input fan_bind_pkg::temp_t a, input fan_bind_pkg::temp_t b);
        return sel ? a : b;
    endfunction

    function automatic logic signed_gt(input fan_bind_pkg::temp_t a,
        input fan_bind_pkg::temp_t b);
        return $signed(a) > $signed(b);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register writes

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shutoff_reg <= fan_bind_pkg::RST_SHUTOFF;
        end else if (reg_req.wr &&
                     is_addr(reg_req.addr, fan_bind_pkg::ADDR_SHUTOFF)) begin
            shutoff_reg <= reg_req.wdata & fan_bind_pkg::SHUTOFF_WMASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bindings_reg <= fan_bind_pkg::RST_BINDINGS;
        end else if (reg_req.wr &&
                     is_addr(reg_req.addr, fan_bind_pkg::ADDR_BINDINGS)) begin
            bindings_reg <= reg_req.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            min_hyst_reg <= fan_bind_pkg::RST_MIN_HYST;
        end else if (reg_req.wr &&
                     is_addr(reg_req.addr, fan_bind_pkg::ADDR_MIN_HYST)) begin
            min_hyst_reg <= reg_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads, one cycle after the strobe

    always_comb begin
        rdata_next = 8'h00;
        if (is_addr(reg_req.addr, fan_bind_pkg::ADDR_SHUTOFF)) begin
            rdata_next = shutoff_reg;
        end else if (is_addr(reg_req.addr, fan_bind_pkg::ADDR_BINDINGS)) begin
            rdata_next = bindings_reg;
        end else if (is_addr(reg_req.addr, fan_bind_pkg::ADDR_MIN_HYST)) begin
            rdata_next = min_hyst_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= reg_req.rd || reg_req.wr;
            if (reg_req.rd) begin
                reg_rdata <= rdata_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode

    assign out2_low_duty_cutoff =
        shutoff_reg[fan_bind_pkg::CUTOFF_MSB:fan_bind_pkg::CUTOFF_LSB];
    assign cutoff_level = {1'b0, out2_low_duty_cutoff, 3'h0};
    assign cutoff_en = out2_filter_coeff != fan_bind_pkg::FILTER_BYPASS;
    assign min_duty = {1'b0,
        min_hyst_reg[fan_bind_pkg::MIN_MSB:fan_bind_pkg::MIN_LSB], 4'h0};

    ////////////////////////////////////////////////////////////////////////
    // Output duty paths

    duty_select u_out1 (
        .use_loop(bindings_reg[fan_bind_pkg::BIT_OUT1_LOOP]),
        .loop_duty(loop_duty),
        .table_duty(table1_duty),
        .min_duty(min_duty),
        .cutoff_en(1'b0),
        .cutoff_level(fan_bind_pkg::DUTY_ZERO),
        .duty_out(out1_next),
        .shut_off()
    );

    duty_select u_out2 (
        .use_loop(bindings_reg[fan_bind_pkg::BIT_OUT2_LOOP]),
        .loop_duty(loop_duty),
        .table_duty(table2_duty),
        .min_duty(min_duty),
        .cutoff_en(cutoff_en),
        .cutoff_level(cutoff_level),
        .duty_out(out2_next),
        .shut_off(out2_cut_next)
    );

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            out1_duty <= fan_bind_pkg::DUTY_ZERO;
            out2_duty <= fan_bind_pkg::DUTY_ZERO;
            out2_cut_active <= 1'b0;
        end else begin
            out1_duty <= out1_next;
            out2_duty <= out2_next;
            out2_cut_active <= out2_cut_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Table temperature sources

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            table_temps <= '0;
        end else begin
            table_temps.table1 <=
                pick(bindings_reg[fan_bind_pkg::BIT_TABLE1_Z1],
                     zone_temps.zone1, zone_temps.zone3);
            table_temps.table2 <=
                pick(bindings_reg[fan_bind_pkg::BIT_TABLE2_Z2],
                     zone_temps.zone2, zone_temps.zone4);
            table_temps.table3 <=
                pick(bindings_reg[fan_bind_pkg::BIT_TABLE3_Z1],
                     zone_temps.zone1, zone_temps.zone3);
            table_temps.table4 <=
                pick(bindings_reg[fan_bind_pkg::BIT_TABLE4_Z2],
                     zone_temps.zone2, zone_temps.zone4);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loop zone binding and regulation band

    always_comb begin
        hot_next = zone_temps.zone1;
        unique case (bindings_reg[fan_bind_pkg::BIT_LOOP_Z2:
                                  fan_bind_pkg::BIT_LOOP_Z1])
            2'b00: hot_next = loop_target;
            2'b01: hot_next = zone_temps.zone1;
            2'b10: hot_next = zone_temps.zone2;
            2'b11: hot_next = signed_gt(zone_temps.zone2, zone_temps.zone1)
                              ? zone_temps.zone2 : zone_temps.zone1;
        endcase
    end

    // Half-degree units, zero appended below so the sign stays in bit 8
    assign hot_half = {loop_hot_temp, 1'b0};
    assign target_half = {loop_target, 1'b0};
    // Half-degree hysteresis
    // Extra bit keeps very low targets from wrapping positive
    assign band_floor_half = {target_half[8], target_half} -
        {6'h00, loop_hysteresis};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            loop_uses_zone1 <= 1'b0;
            loop_uses_zone2 <= 1'b0;
            loop_hot_temp <= 8'h00;
            loop_hysteresis <= 4'h0;
            loop_min_duty <= fan_bind_pkg::DUTY_ZERO;
        end else begin
            loop_uses_zone1 <= bindings_reg[fan_bind_pkg::BIT_LOOP_Z1];
            loop_uses_zone2 <= bindings_reg[fan_bind_pkg::BIT_LOOP_Z2];
            loop_hot_temp <= hot_next;
            loop_hysteresis <=
                min_hyst_reg[fan_bind_pkg::HYST_MSB:fan_bind_pkg::HYST_LSB];
            loop_min_duty <= min_duty;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            loop_above_target <= 1'b0;
            loop_below_band <= 1'b0;
        end else begin
            loop_above_target <= $signed(hot_half) > $signed(target_half);
            loop_below_band <=
                $signed({hot_half[8], hot_half}) < $signed(band_floor_half);
        end
    end
endmodule

/* File: pkg/fan_bind_pkg.sv */
// Package with register map, field layouts and types for the fan bindings
// How it works
// - Shutoff threshold is field times eight
// - Filter bypassed disables the shutoff compare
// - Duty below threshold turns output 2 off
// - Bit 0 binds loop to zone 1
// - Bit 1 binds loop to zone 2
// - Bit 2 drives output 1 from loop
// - Bit 3 drives output 2 from loop
// - Bit 4 feeds table 1 zone 1
// - Bit 5 feeds table 2 zone 2
// - Bit 6 feeds table 3 zone 1
// - Bit 7 feeds table 4 zone 2
// - Hysteresis field in half-degree steps
// - Loop duty below minimum field only when output 2 cutoff zeroes it
// - Loop regulates hotter bound zone in band
// - Filter coefficient zero means filter bypassed
package fan_bind_pkg;
    localparam logic [7:0] ADDR_SHUTOFF = 8'h34;
    localparam logic [7:0] ADDR_BINDINGS = 8'h35;
    localparam logic [7:0] ADDR_MIN_HYST = 8'h36;

    localparam logic [7:0] RST_SHUTOFF = 8'h00;
    localparam logic [7:0] RST_BINDINGS = 8'h30;
    localparam logic [7:0] RST_MIN_HYST = 8'h00;

    localparam logic [7:0] SHUTOFF_WMASK = 8'hf8;
    localparam int CUTOFF_LSB = 3;
    localparam int CUTOFF_MSB = 7;
    localparam int HYST_LSB = 0;
    localparam int HYST_MSB = 3;
    localparam int MIN_LSB = 4;
    localparam int MIN_MSB = 7;

    localparam int BIT_LOOP_Z1 = 0;
    localparam int BIT_LOOP_Z2 = 1;
    localparam int BIT_OUT1_LOOP = 2;
    localparam int BIT_OUT2_LOOP = 3;
    localparam int BIT_TABLE1_Z1 = 4;
    localparam int BIT_TABLE2_Z2 = 5;
    localparam int BIT_TABLE3_Z1 = 6;
    localparam int BIT_TABLE4_Z2 = 7;

    // Duty is 9 bits, 256 counts = 100 %
    localparam int DUTY_W = 9;
    localparam logic [2:0] FILTER_BYPASS = 3'h0;
    localparam logic [8:0] DUTY_ZERO = 9'h000;

    typedef logic [7:0] temp_t;
    typedef logic [8:0] duty_t;

    typedef struct packed {
        temp_t zone1;
        temp_t zone2;
        temp_t zone3;
        temp_t zone4;
    } zone_temps_t;

    typedef struct packed {
        temp_t table1;
        temp_t table2;
        temp_t table3;
        temp_t table4;
    } table_temps_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

/* File: testbench/fan_bind_monitor.sv */
// Port assertions for the fan binding registers
`timescale 1ns/10ps
module fan_bind_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire fan_bind_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic [2:0] out2_filter_coeff,
    input wire fan_bind_pkg::duty_t out2_duty,
    input wire logic out2_cut_active,
    input wire logic loop_above_target,
    input wire logic loop_below_band,
    input wire logic [3:0] loop_hysteresis,
    input wire fan_bind_pkg::duty_t loop_min_duty
);
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Read request answered one cycle later
    sequence s_rd(a);
        reg_req.rd && reg_req.addr == a ##1 reg_ack;
    endsequence
    a_ack_req: assert property ((reg_req.wr || reg_req.rd) |=> reg_ack)
        else $error("no ack after request");
    a_rsv_zero: assert property (
        s_rd(8'h34) |-> reg_rdata[2:0] == 3'h0)
        else $error("reserved bits not zero");
    a_unmapped_zero: assert property (reg_req.rd &&
        !(reg_req.addr inside {8'h34, 8'h35, 8'h36}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_hyst_field: assert property (
        s_rd(8'h36) |-> loop_hysteresis == reg_rdata[3:0])
        else $error("hysteresis differs from field");
    a_min_field: assert property (
        s_rd(8'h36) |-> loop_min_duty == {1'b0, reg_rdata[7:4], 4'h0})
        else $error("minimum duty differs from field");
    a_cut_zero: assert property (
        out2_cut_active |-> out2_duty == 9'h000)
        else $error("cut output not zero");
    a_cut_filter: assert property (
        out2_cut_active |-> $past(out2_filter_coeff) != 3'h0)
        else $error("cut while filter bypassed");
    a_flags_excl: assert property (
        !(loop_above_target && loop_below_band))
        else $error("above and below together");
endmodule

bind fan_bind_regs fan_bind_monitor mon (.clk_sys, .rst_n, .reg_req,
    .reg_rdata, .reg_ack, .out2_filter_coeff, .out2_duty, .out2_cut_active,
    .loop_above_target, .loop_below_band, .loop_hysteresis, .loop_min_duty);

/* File: testbench/tb_top.sv */
// Self-checking bench for the fan binding registers
`timescale 1ns/10ps
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    fan_bind_pkg::reg_req_t reg_req = '0;
    logic [7:0] reg_rdata, q;
    logic reg_ack, out2_cut_active, loop_uses_zone1, loop_uses_zone2;
    logic loop_above_target, loop_below_band;
    logic [2:0] out2_filter_coeff = 3'h0;
    fan_bind_pkg::zone_temps_t zone_temps = 32'h11223344;
    fan_bind_pkg::temp_t loop_target = 8'h00, loop_hot_temp;
    fan_bind_pkg::duty_t loop_duty = 9'h000, table1_duty = 9'h055;
    fan_bind_pkg::duty_t table2_duty = 9'h066;
    fan_bind_pkg::duty_t out1_duty, out2_duty, loop_min_duty;
    fan_bind_pkg::table_temps_t table_temps;
    logic [3:0] loop_hysteresis;
    int err_total = 0;
    int cmp_count = 0;

    always #2 clk_sys = ~clk_sys;

    fan_bind_regs dut (.clk_sys, .rst_n, .reg_req, .reg_rdata, .reg_ack,
        .out2_filter_coeff, .zone_temps, .loop_target, .loop_duty,
        .table1_duty, .table2_duty, .table_temps, .out1_duty, .out2_duty,
        .out2_cut_active, .loop_uses_zone1, .loop_uses_zone2,
        .loop_hot_temp, .loop_above_target, .loop_below_band,
        .loop_hysteresis, .loop_min_duty);

    ////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge clk_sys);
        reg_req.wr <= 1'b0;
        reg_req.rd <= 1'b0;
        @(posedge clk_sys);
        chk("ack", 32'(reg_ack), 32'h1);
        q = reg_rdata;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00);
        chk("rdata", 32'(q), 32'(e));
    endtask

    task wait3;
        repeat (3) @(posedge clk_sys);
    endtask

    function automatic logic [31:0] sel(input logic [7:0] b);
        return {b[4] ? 8'h11 : 8'h33, b[5] ? 8'h22 : 8'h44,
                b[6] ? 8'h11 : 8'h33, b[7] ? 8'h22 : 8'h44};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task t_bind;
        logic [7:0] b;
        rd(8'h34, 8'h00);
        rd(8'h36, 8'h00);
        rd(8'h37, 8'h00);
        for (int i = 0; i < 3; i++) begin
            b = (i == 0) ? 8'h30 : (i == 1) ? 8'hc3 : 8'h3c;
            if (i > 0) wr(8'h35, b);
            rd(8'h35, b);
            wait3;
            chk("tables", table_temps, sel(b));
            chk("zones", 32'({loop_uses_zone2, loop_uses_zone1}),
                32'(b[1:0]));
        end
    endtask

    task t_loop;
        wr(8'h36, 8'hf4);
        wr(8'h35, 8'h0c);
        loop_duty <= 9'h010;
        wait3;
        chk("out1", 32'(out1_duty), 32'd240);
        chk("out2", 32'(out2_duty), 32'd240);
        chk("min", 32'(loop_min_duty), 32'd240);
        chk("hyst", 32'(loop_hysteresis), 32'h4);
        rd(8'h36, 8'hf4);
        loop_duty <= 9'h100;
        wait3;
        chk("out1", 32'(out1_duty), 32'h100);
        wr(8'h35, 8'h00);
        wait3;
        chk("out1", 32'(out1_duty), 32'h055);
        chk("out2", 32'(out2_duty), 32'h066);
    endtask

    task cut(input logic [2:0] c, input logic [8:0] d, input logic [8:0] e);
        out2_filter_coeff <= c;
        table2_duty <= d;
        wait3;
        chk("out2", 32'(out2_duty), 32'(e));
        chk("cut", 32'(out2_cut_active), 32'(e == 9'h0 && d != 9'h0));
    endtask

    task t_cut;
        wr(8'h34, 8'hff);
        rd(8'h34, 8'hf8);
        cut(3'h1, 9'd247, 9'd0);
        cut(3'h7, 9'd248, 9'd248);
        cut(3'h0, 9'd247, 9'd247);
        wr(8'h34, 8'h08);
        cut(3'h4, 9'd7, 9'd0);
        cut(3'h4, 9'd8, 9'd8);
    endtask

    task hot(input logic [7:0] t, input logic [7:0] h, input logic [1:0] e);
        loop_target <= t;
        wait3;
        chk("hot", 32'(loop_hot_temp), 32'(h));
        chk("flags", 32'({loop_above_target, loop_below_band}), 32'(e));
    endtask

    task t_hyst;
        wr(8'h36, 8'h04);
        zone_temps <= 32'h3c460000;
        wr(8'h35, 8'h03);
        hot(8'd70, 8'd70, 2'b00);
        hot(8'd69, 8'd70, 2'b10);
        hot(8'd72, 8'd70, 2'b00);
        hot(8'd73, 8'd70, 2'b01);
        wr(8'h35, 8'h01);
        hot(8'd60, 8'd60, 2'b00);
        wr(8'h35, 8'h02);
        hot(8'd60, 8'd70, 2'b10);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_bind;
        t_loop;
        t_cut;
        t_hyst;
        finish_test;
    end

    // Hang guard, well beyond the roughly 120 cycles needed
    initial begin
        #20000;
        err_total++;
        finish_test;
    end
endmodule
